/* File: reset_ctrl_map.vh */
// Offsets, field positions, reset values and cycle counts of the reset controller.
// Assumes a 50 MHz pclk and a one-cycle ipo_tick pulse per oscillator cycle.
`ifndef RESET_CTRL_MAP_VH
`define RESET_CTRL_MAP_VH

`define STATUS_CTRL_OFFSET 12'h000
`define DEBUG_CTRL_OFFSET 12'h004
`define OPTION_OFFSET 12'h008
`define RECOVERY_EN_OFFSET 12'h00c
`define STATE_OFFSET 12'h010

`define ST_POWER_ON_BIT 7
`define ST_STOP_BIT 6
`define ST_WATCHDOG_BIT 5
`define ST_PIN_BIT 4
`define ST_FAULT_BIT 3
`define ST_SOFTWARE_BIT 2
`define ST_TRIGGER_BIT 0
`define DBG_TRIGGER_BIT 0
`define OPT_WDT_SEL_BIT 0
`define OPT_BO_STOP_BIT 1
`define OPT_PWM_OFF_LSB 8

`define STATUS_RESET 6'h20
`define WDT_SEL_RESET 1'b1
`define BO_STOP_RESET 1'b0

`define OSC_PHASE_CYCLES 6'd50
`define SYS_PHASE_CYCLES 5'd16
`define PIN_MIN_LOW_CYCLES 3'd4
`define PIN_SETTLE_CYCLES 5'd3
`define RESET_VECTOR 32'h00000004

`endif

/* File: reset_ctrl.v */
// Reset and stop-mode recovery controller with APB register access.
// Assumes all inputs synchronous to pclk except reset_pin_in; ipo_tick marks oscillator cycles.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "reset_ctrl_map.vh"

module reset_ctrl #(
  parameter GPIO_W = 8,
  parameter PWM_W = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire debugger_write,
  input wire ipo_tick,
  input wire supply_ok,
  input wire brown_out,
  input wire watchdog_timeout,
  input wire fault_detect,
  input wire stop_mode,
  input wire [GPIO_W-1:0] gpio_in,
  input wire opt_wdt_sel_in,
  input wire opt_bo_stop_in,
  input wire [PWM_W-1:0] opt_pwm_off_in,
  input wire reset_pin_in,
  output wire reset_pin_out,
  output reg reset_pin_oe,
  output reg sys_reset,
  output reg sysclk_run,
  output reg gpio_force_input,
  output reg pullup_disable,
  output reg pwm_float,
  output reg pwm_off_force,
  output reg [PWM_W-1:0] pwm_off_level,
  output reg debugger_exempt,
  output reg stop_recovery,
  output reg fetch_vector,
  output wire [31:0] reset_vector_addr
);

  localparam S_IDLE = 6'b000001;
  localparam S_OSC = 6'b000010;
  localparam S_SYS = 6'b000100;
  localparam S_CHECK = 6'b001000;
  localparam S_WAIT = 6'b010000;
  localparam S_TAIL = 6'b100000;

  // Cause codes as stored in status_reg, which holds status bits 7..2
  localparam [5:0] CAUSE_POWER_ON = 6'h01 << (`ST_POWER_ON_BIT - `ST_SOFTWARE_BIT);
  localparam [5:0] CAUSE_STOP = 6'h01 << (`ST_STOP_BIT - `ST_SOFTWARE_BIT);
  localparam [5:0] CAUSE_WATCHDOG = 6'h01 << (`ST_WATCHDOG_BIT - `ST_SOFTWARE_BIT);
  localparam [5:0] CAUSE_PIN = 6'h01 << (`ST_PIN_BIT - `ST_SOFTWARE_BIT);
  localparam [5:0] CAUSE_FAULT = 6'h01 << (`ST_FAULT_BIT - `ST_SOFTWARE_BIT);
  localparam [5:0] CAUSE_SOFTWARE = 6'h01;

  reg [5:0] state_reg, state_next;
  reg [5:0] osc_cnt_reg, osc_cnt_next;
  reg [4:0] sys_cnt_reg, sys_cnt_next;
  reg [5:0] status_reg, status_next;
  reg recov_reg, recov_next;
  reg exempt_next;
  reg dbg_ctl_reg;
  reg opt_wdt_sel_reg;
  reg opt_bo_stop_reg;
  reg [PWM_W-1:0] opt_pwm_off_reg;
  reg [GPIO_W-1:0] rec_en_reg;
  reg [GPIO_W-1:0] gpio_prev_reg;
  reg pin_sync1_reg, pin_sync2_reg;
  reg [2:0] pin_low_cnt_reg;

  wire wr_access = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire sw_trigger = wr_access & (paddr == `STATUS_CTRL_OFFSET) & pwdata[`ST_TRIGGER_BIT];
  wire run_mode = ~stop_mode;
  wire idle = state_reg[0];

  assign pready = 1'b1;
  assign reset_pin_out = 1'b0;
  assign reset_vector_addr = `RESET_VECTOR;

  // Reset pin synchroniser and low-time filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_reg <= 1'b1;
      pin_sync2_reg <= 1'b1;
      pin_low_cnt_reg <= 3'd0;
    end else begin
      pin_sync1_reg <= reset_pin_in;
      pin_sync2_reg <= pin_sync1_reg;
      if (pin_sync2_reg)
        pin_low_cnt_reg <= 3'd0;
      else if (pin_low_cnt_reg != `PIN_MIN_LOW_CYCLES)
        pin_low_cnt_reg <= pin_low_cnt_reg + 3'd1;
    end
  end

  wire pin_low = ~pin_sync2_reg;
  // Filter bypassed in stop mode
  wire pin_req = stop_mode ? pin_low : (pin_low_cnt_reg == `PIN_MIN_LOW_CYCLES);

  wire supply_hold = ~supply_ok | (brown_out & (run_mode | opt_bo_stop_reg));
  wire wdt_req = run_mode & watchdog_timeout & opt_wdt_sel_reg;
  wire sw_req = run_mode & sw_trigger;
  wire dbg_req = run_mode & dbg_ctl_reg;
  wire [GPIO_W-1:0] gpio_chg = (gpio_in ^ gpio_prev_reg) & rec_en_reg;
  wire rec_req = stop_mode & (watchdog_timeout | (|gpio_chg));

  // Sequencer
  always @* begin
    state_next = state_reg;
    osc_cnt_next = osc_cnt_reg;
    sys_cnt_next = sys_cnt_reg;
    status_next = status_reg;
    recov_next = recov_reg;
    exempt_next = debugger_exempt;
    if (supply_hold) begin
      // Count starts only once the supply has settled
      state_next = S_OSC;
      osc_cnt_next = 6'd0;
      recov_next = 1'b0;
      exempt_next = 1'b0;
      status_next = CAUSE_POWER_ON;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (fault_detect | wdt_req | pin_req | sw_req | dbg_req) begin
            state_next = S_OSC;
            osc_cnt_next = 6'd0;
            recov_next = 1'b0;
            exempt_next = dbg_req | (sw_req & debugger_write);
            if (fault_detect)
              status_next = CAUSE_FAULT;
            else if (wdt_req)
              status_next = CAUSE_WATCHDOG;
            else if (pin_req)
              status_next = CAUSE_PIN;
            else
              status_next = CAUSE_SOFTWARE;
          end else if (rec_req) begin
            state_next = S_OSC;
            osc_cnt_next = 6'd0;
            recov_next = 1'b1;
            exempt_next = 1'b0;
            status_next = watchdog_timeout ? (CAUSE_STOP | CAUSE_WATCHDOG) : CAUSE_STOP;
          end
        end
        S_OSC: begin
          if (ipo_tick) begin
            if (osc_cnt_reg == `OSC_PHASE_CYCLES - 6'd1) begin
              state_next = S_SYS;
              sys_cnt_next = 5'd0;
            end else begin
              osc_cnt_next = osc_cnt_reg + 6'd1;
            end
          end
        end
        S_SYS: begin
          if (sys_cnt_reg == `SYS_PHASE_CYCLES - 5'd1) begin
            sys_cnt_next = 5'd0;
            state_next = recov_reg ? S_IDLE : S_CHECK;
          end else begin
            sys_cnt_next = sys_cnt_reg + 5'd1;
          end
        end
        S_CHECK: begin
          // Own drive released; let the synchroniser see the true pin level
          if (sys_cnt_reg == `PIN_SETTLE_CYCLES - 5'd1) begin
            sys_cnt_next = 5'd0;
            state_next = pin_low ? S_WAIT : S_IDLE;
          end else begin
            sys_cnt_next = sys_cnt_reg + 5'd1;
          end
        end
        S_WAIT: begin
          sys_cnt_next = 5'd0;
          if (!pin_low)
            state_next = S_TAIL;
        end
        S_TAIL: begin
          if (pin_low) begin
            state_next = S_WAIT;
            sys_cnt_next = 5'd0;
          end else if (sys_cnt_reg == `SYS_PHASE_CYCLES - 5'd1) begin
            state_next = S_IDLE;
            sys_cnt_next = 5'd0;
          end else begin
            sys_cnt_next = sys_cnt_reg + 5'd1;
          end
        end
        default: begin
          state_next = S_IDLE;
        end
      endcase
    end
  end

  wire entering = idle & ~state_next[0];
  wire sys_entry = entering & ~recov_next;
  wire opt_load = state_reg[1] & state_next[2] & ~recov_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_OSC;
      osc_cnt_reg <= 6'd0;
      sys_cnt_reg <= 5'd0;
      status_reg <= `STATUS_RESET;
      recov_reg <= 1'b0;
      debugger_exempt <= 1'b0;
      dbg_ctl_reg <= 1'b0;
      opt_wdt_sel_reg <= `WDT_SEL_RESET;
      opt_bo_stop_reg <= `BO_STOP_RESET;
      opt_pwm_off_reg <= {PWM_W{1'b0}};
      rec_en_reg <= {GPIO_W{1'b0}};
      gpio_prev_reg <= {GPIO_W{1'b0}};
      sys_reset <= 1'b1;
      sysclk_run <= 1'b0;
      reset_pin_oe <= 1'b1;
      gpio_force_input <= 1'b1;
      pullup_disable <= 1'b1;
      pwm_float <= 1'b1;
      pwm_off_force <= 1'b0;
      pwm_off_level <= {PWM_W{1'b0}};
      stop_recovery <= 1'b0;
      fetch_vector <= 1'b0;
    end else begin
      state_reg <= state_next;
      osc_cnt_reg <= osc_cnt_next;
      sys_cnt_reg <= sys_cnt_next;
      status_reg <= status_next;
      recov_reg <= recov_next;
      debugger_exempt <= exempt_next;
      gpio_prev_reg <= gpio_in;
      // Debugger request consumed at entry so it cannot retrigger
      if (sys_entry | supply_hold)
        dbg_ctl_reg <= 1'b0;
      else if (wr_access & (paddr == `DEBUG_CTRL_OFFSET))
        dbg_ctl_reg <= pwdata[`DBG_TRIGGER_BIT];
      if (opt_load) begin
        opt_wdt_sel_reg <= opt_wdt_sel_in;
        opt_bo_stop_reg <= opt_bo_stop_in;
        opt_pwm_off_reg <= opt_pwm_off_in;
      end
      if (sys_entry | supply_hold)
        rec_en_reg <= {GPIO_W{1'b0}};
      else if (wr_access & (paddr == `RECOVERY_EN_OFFSET))
        rec_en_reg <= pwdata[GPIO_W-1:0];
      sys_reset <= ~state_next[0];
      sysclk_run <= ~state_next[1];
      reset_pin_oe <= ~recov_next & (state_next[1] | state_next[2]);
      gpio_force_input <= ~recov_next & ~state_next[0];
      pullup_disable <= ~recov_next & ~state_next[0];
      pwm_float <= ~recov_next & state_next[1];
      pwm_off_force <= ~recov_next & ~state_next[0] & ~state_next[1];
      pwm_off_level <= opt_load ? opt_pwm_off_in : opt_pwm_off_reg;
      stop_recovery <= recov_next & ~state_next[0];
      fetch_vector <= ~state_reg[0] & state_next[0];
    end
  end

  // APB read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      case (paddr)
        `STATUS_CTRL_OFFSET: prdata <= {24'h000000, status_reg, 2'b00};
        `DEBUG_CTRL_OFFSET: prdata <= {31'h00000000, dbg_ctl_reg};
        `OPTION_OFFSET: prdata <= {{(24 - PWM_W){1'b0}}, opt_pwm_off_reg, 6'h00,
                                   opt_bo_stop_reg, opt_wdt_sel_reg};
        `RECOVERY_EN_OFFSET: prdata <= {{(32 - GPIO_W){1'b0}}, rec_en_reg};
        `STATE_OFFSET: prdata <= {24'h000000, recov_reg, debugger_exempt, state_reg};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule // reset_ctrl

/* File: reset_ctrl_monitor.sv */
// Concurrent checks on the reset controller ports.
// Assumes a bind into reset_ctrl and one pclk domain.
`timescale 1ns/100ps
module reset_ctrl_monitor (
  input wire pclk,
  input wire presetn,
  input wire ipo_tick,
  input wire supply_ok,
  input wire brown_out,
  input wire fault_detect,
  input wire watchdog_timeout,
  input wire stop_mode,
  input wire reset_pin_in,
  input wire reset_pin_oe,
  input wire sys_reset,
  input wire sysclk_run,
  input wire gpio_force_input,
  input wire pullup_disable,
  input wire pwm_float,
  input wire pwm_off_force,
  input wire stop_recovery,
  input wire fetch_vector,
  input wire [31:0] reset_vector_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [6:0] tick_cnt;
  wire idle = !sys_reset && !stop_recovery;
  // Oscillator cycles seen in the float phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 7'h00;
    else if (!pwm_float || brown_out || !supply_ok)
      tick_cnt <= 7'h00;
    else if (ipo_tick)
      tick_cnt <= tick_cnt + 7'h01;
  end
  a_fault_starts_reset: assert property (idle && fault_detect |=> sys_reset && gpio_force_input)
    else $error("fault did not start a system reset");
  a_stop_wakes_up: assert property (idle && stop_mode && watchdog_timeout |=> stop_recovery)
    else $error("watchdog in stop did not start recovery");
  a_entry_pins_safe: assert property ($rose(gpio_force_input) |-> sys_reset && pullup_disable
    && pwm_float && reset_pin_oe && !sysclk_run)
    else $error("reset entry outputs wrong");
  a_osc_phase_len: assert property ($fell(pwm_float) |-> pwm_off_force && sysclk_run
    && tick_cnt >= 7'd49 && tick_cnt <= 7'd51)
    else $error("oscillator phase length wrong");
  a_sys_phase_len: assert property ($rose(sysclk_run) && gpio_force_input
    |-> ##15 reset_pin_oe ##[1:2] !reset_pin_oe)
    else $error("system clock phase length wrong");
  a_release_fetch: assert property ($fell(sys_reset) |-> ##[0:1] fetch_vector)
    else $error("no vector fetch after release");
  a_release_pin_high: assert property ($fell(sys_reset) |-> reset_pin_in && !reset_pin_oe)
    else $error("left reset while pin low");
  a_vector_fixed: assert property (reset_vector_addr == 32'h00000004)
    else $error("reset vector address wrong");
  a_recovery_pins_free: assert property (stop_recovery |-> !reset_pin_oe && !gpio_force_input)
    else $error("recovery touched pins");
endmodule // reset_ctrl_monitor
bind reset_ctrl reset_ctrl_monitor u_mon (.*);

/* File: board_reset_line.sv */
// Board side of the open-drain reset line: pull-up plus a push button.
// Assumes the device enable sinks the line while high.
`timescale 1ns/100ps
module board_reset_line (
  input wire reset_pin_oe,
  input wire button_low,
  output wire reset_line
);
  // Pull-up only wins when nobody sinks the line
  assign reset_line = (reset_pin_oe || button_low) ? 1'b0 : 1'b1;
endmodule // board_reset_line

/* File: reset_ctrl_bench.sv */
// Self-checking bench: APB master, reset cause table, pin and stop scenarios.
// Assumes reset_ctrl_map.vh offsets and the board_reset_line model.
`timescale 1ns/100ps
`include "reset_ctrl_map.vh"
module reset_ctrl_bench;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, seed = 32'd84883;
  reg debugger_write = 1'b0, ipo_tick = 1'b0, supply_ok = 1'b1, brown_out = 1'b0;
  reg watchdog_timeout = 1'b0, fault_detect = 1'b0, stop_mode = 1'b0, button_low = 1'b0;
  reg opt_wdt_sel_in = 1'b1, opt_bo_stop_in = 1'b0;
  reg [7:0] gpio_in = 8'h00;
  reg [5:0] opt_pwm_off_in = 6'h00;
  reg [1:0] div = 2'h0;
  wire pready, pslverr, reset_pin_out, reset_pin_oe, sys_reset, sysclk_run, gpio_force_input;
  wire pullup_disable, pwm_float, pwm_off_force, debugger_exempt, stop_recovery, fetch_vector;
  wire reset_line;
  wire reset_pin_in = reset_line;
  wire [31:0] prdata, reset_vector_addr;
  wire [5:0] pwm_off_level;
  logic [32:0] exp_q[$];
  int fail_count = 0, n_checks = 0, k, n;
  byte cause_tab[9] = '{8'h08, 8'h20, 8'h04, 8'h04, 8'h10, 8'h10, 8'h60, 8'h40, 8'h80};
  reset_ctrl dut (.*);
  board_reset_line board (.*);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    ipo_tick <= (div == 2'h2);
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string nm, input [32:0] seen, input [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task wait_idle;
    int i;
    cyc(4);
    for (i = 0; i < 3000 && (sys_reset || stop_recovery); i++)
      cyc(1);
    if (i == 3000) begin
      fail_count++;
      print_verdict;
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d, input [32:0] e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 50);
    if (i == 50) begin
      fail_count++;
      print_verdict;
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Read data checked at the completing access edge
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
  task fire(input int c);
    case (c)
      0: fault_detect <= 1'b1;
      1: watchdog_timeout <= 1'b1;
      2: apb(`STATUS_CTRL_OFFSET, 1'b1, 32'h1, 33'h0);
      3: begin
        debugger_write <= 1'b1;
        apb(`DEBUG_CTRL_OFFSET, 1'b1, 32'h1, 33'h0);
        debugger_write <= 1'b0;
        cyc(3);
        check("debugger_exempt", debugger_exempt, 1'b1);
      end
      4: begin
        button_low <= 1'b1;
        cyc(8 + seed[1:0]);
        button_low <= 1'b0;
        cyc(4);
        check("reset_line", reset_line, 1'b0);
        check("reset_pin_out", reset_pin_out, 1'b0);
      end
      5: begin
        button_low <= 1'b1;
        cyc(400);
        check("sys_reset", sys_reset, 1'b1);
        button_low <= 1'b0;
        for (n = 0; n < 40 && sys_reset; n++)
          cyc(1);
        check("release", n >= 16 && n <= 21, 1'b1);
      end
      6: begin
        apb(`RECOVERY_EN_OFFSET, 1'b1, 32'hff, 33'h0);
        stop_mode <= 1'b1;
        apb(`STATUS_CTRL_OFFSET, 1'b1, 32'h1, 33'h0);
        cyc(5);
        check("sys_reset", sys_reset, 1'b0);
        watchdog_timeout <= 1'b1;
      end
      7: begin
        stop_mode <= 1'b1;
        cyc(2);
        gpio_in <= gpio_in ^ 8'h01;
      end
      default: begin
        apb(`RECOVERY_EN_OFFSET, 1'b0, 32'h0, 33'hff);
        supply_ok <= 1'b0;
        brown_out <= 1'b1;
        opt_wdt_sel_in <= 1'b0;
        cyc(20);
        check("sys_reset", sys_reset, 1'b1);
        supply_ok <= 1'b1;
        brown_out <= 1'b0;
      end
    endcase
    cyc(1);
    fault_detect <= 1'b0;
    watchdog_timeout <= 1'b0;
  endtask
  initial begin
    seed = lfsr(seed);
    opt_pwm_off_in <= seed[5:0];
    gpio_in <= seed[15:8];
    cyc(2);
    presetn <= 1'b1;
    wait_idle;
    apb(`STATUS_CTRL_OFFSET, 1'b0, 32'h0, 33'h80);
    apb(`OPTION_OFFSET, 1'b0, 32'h0, {19'h0, opt_pwm_off_in, 6'h00, opt_bo_stop_in,
      opt_wdt_sel_in});
    check("pwm_off_level", pwm_off_level, opt_pwm_off_in);
    apb(12'hffc, 1'b0, 32'h0, {1'b1, 32'h0});
    for (k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      fire(k);
      wait_idle;
      stop_mode <= 1'b0;
      apb(`STATUS_CTRL_OFFSET, 1'b0, 32'h0, {25'h0, cause_tab[k]});
    end
    apb(`RECOVERY_EN_OFFSET, 1'b0, 32'h0, 33'h0);
    apb(`STATE_OFFSET, 1'b0, 32'h0, 33'h1);
    // Watchdog with reset select cleared must not reset
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    cyc(4);
    check("sys_reset", sys_reset, 1'b0);
    apb(`OPTION_OFFSET, 1'b0, 32'h0, {19'h0, opt_pwm_off_in, 6'h00, opt_bo_stop_in, 1'b0});
    cyc(3);
    print_verdict;
  end
endmodule // reset_ctrl_bench
